// [hw/pss_pkg.sv]
// Purpose: Constants and types of the preset speed selector.
// Assumes: Frequencies are held in units of 0.1 Hz.
// Notes:   APB offsets are byte addresses, one 32-bit word per register.
package pss_pkg;

  // Frequency word with its valid flag
  typedef struct packed {
    logic        valid;
    logic [15:0] freq;
  } pss_freq_t;

  // Which source drives the command
  typedef enum logic [2:0] {
    PSS_SRC_NONE,
    PSS_SRC_JOG,
    PSS_SRC_PRESET,
    PSS_SRC_AN4,
    PSS_SRC_AN2
  } pss_src_t;

  localparam int          PSS_NUM_PRESET = 15;
  localparam int          PSS_NUM_TERM   = 5;
  localparam logic [7:0]  PSS_OFS_PRESET = 8'h00; // Speed 1 to 15, 4 apart
  localparam logic [7:0]  PSS_OFS_CONFIG = 8'h40;
  localparam logic [7:0]  PSS_OFS_TERMFN = 8'h44;
  localparam logic [7:0]  PSS_OFS_STATUS = 8'h48;

  localparam logic [15:0] PSS_UNUSED     = 16'h270F; // 9999
  localparam logic [15:0] PSS_FREQ_MAX   = 16'h0FA0; // 400.0 Hz
  localparam logic [3:0]  PSS_FIRST_EXT  = 4'h4;     // First extended speed

  // Terminal function codes
  localparam logic [3:0]  PSS_FN_LOW     = 4'h0;
  localparam logic [3:0]  PSS_FN_MIDDLE  = 4'h1;
  localparam logic [3:0]  PSS_FN_HIGH    = 4'h2;
  localparam logic [3:0]  PSS_FN_EXT     = 4'h8;

  // Config fields: write sel [7:0], display sel [15:8], remote [23:16]
  localparam int          PSS_CFG_PWS    = 0;
  localparam int          PSS_CFG_EDS    = 8;
  localparam int          PSS_CFG_RSS    = 16;
  localparam logic [31:0] PSS_CFG_RST    = 32'h0000_0000;
  // Terminals 0..2 low, middle, high; 3 and 4 free (code F)
  localparam logic [19:0] PSS_TERMFN_RST = 20'hF_F210;

  // Speed 1 high, 2 middle, 3 low, then 4..15 unused
  localparam logic [15:0] PSS_PRESET_RST [PSS_NUM_PRESET] = '{
    16'h0258, 16'h012C, 16'h0064,
    16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h270F,
    16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h270F};

  // Speed for index {ext, high, middle, low}
  localparam logic [3:0]  PSS_SPEED_LUT [16] = '{
    4'h0, 4'h3, 4'h2, 4'h5, 4'h1, 4'h6, 4'h4, 4'h7,
    4'h8, 4'hB, 4'hA, 4'hD, 4'h9, 4'hE, 4'hC, 4'hF};

endpackage

// [hw/pss_selector.sv]
// Purpose: Preset speed selector with APB register access.
// Assumes: Contact terminals are asynchronous; source inputs share pclk.
// Notes:   Zero-wait APB slave; bad writes return pslverr and are dropped.
`timescale 1ns/1ns
`default_nettype none
module pss_selector (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [4:0]        term_pin,
  input  wire pss_pkg::pss_freq_t jog_src,
  input  wire pss_pkg::pss_freq_t an4_src,
  input  wire pss_pkg::pss_freq_t an2_src,
  output pss_pkg::pss_freq_t     freq_cmd,
  output pss_pkg::pss_src_t      freq_source,
  output logic [3:0]             speed_sel
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [4:0]         sync1_q, sync1_d, sync2_q, sync2_d;
  logic [15:0]        preset_q [pss_pkg::PSS_NUM_PRESET];
  logic [15:0]        preset_d [pss_pkg::PSS_NUM_PRESET];
  logic [31:0]        cfg_q, cfg_d;
  logic [19:0]        termfn_q, termfn_d;
  logic [31:0]        prdata_q, prdata_d;
  pss_pkg::pss_freq_t freq_q, freq_d;
  pss_pkg::pss_src_t  src_q, src_d;
  logic [3:0]         speed_q, speed_d;
  logic [3:0]         fn_hit [pss_pkg::PSS_NUM_TERM];
  logic               sel_low, sel_mid, sel_high, sel_ext;
  logic [3:0]         combo, lut_speed, basic_speed, sel_speed;
  logic [15:0]        lut_freq, sel_freq;
  logic [7:0]         eds, rss;
  logic               wr_acc, rd_setup, is_preset, wr_ok, addr_ok;
  logic [3:0]         pidx;
  logic [15:0]        wval;

  assign eds = cfg_q[pss_pkg::PSS_CFG_EDS +: 8];
  assign rss = cfg_q[pss_pkg::PSS_CFG_RSS +: 8];

  ////////////////////////////////////////////////////////////////////////
  // Terminal synchroniser; only the second stage feeds logic
  always_comb begin
    sync1_d = term_pin;
    sync2_d = sync1_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-terminal function decode: {ext, high, middle, low}
  for (genvar t = 0; t < pss_pkg::PSS_NUM_TERM; t++) begin : g_term
    logic [3:0] code;
    assign code = termfn_q[4*t +: 4];
    assign fn_hit[t] = {
      sync2_q[t] && (code == pss_pkg::PSS_FN_EXT),
      sync2_q[t] && (code == pss_pkg::PSS_FN_HIGH),
      sync2_q[t] && (code == pss_pkg::PSS_FN_MIDDLE),
      sync2_q[t] && (code == pss_pkg::PSS_FN_LOW)};
  end

  // Any terminal carrying a function turns that function on
  always_comb begin
    combo = 4'h0;
    for (int t = 0; t < pss_pkg::PSS_NUM_TERM; t++) begin
      combo = combo | fn_hit[t];
    end
  end

  assign sel_low  = combo[0];
  assign sel_mid  = combo[1];
  assign sel_high = combo[2];
  assign sel_ext  = combo[3];

  ////////////////////////////////////////////////////////////////////////
  // Speed choice; an unused extended speed falls back to the basic rule, or to low for extension alone
  always_comb begin
    lut_speed = pss_pkg::PSS_SPEED_LUT[combo];
    lut_freq  = (lut_speed == 4'h0) ? pss_pkg::PSS_UNUSED
                                    : preset_q[lut_speed - 4'h1];
    if (sel_low) begin
      basic_speed = 4'h3;
    end else if (sel_mid) begin
      basic_speed = 4'h2;
    end else if (sel_high) begin
      basic_speed = 4'h1;
    end else begin
      basic_speed = 4'h0;
    end
    if (rss != 8'h00) begin
      sel_speed = 4'h0;
    end else if (lut_speed >= pss_pkg::PSS_FIRST_EXT &&
                 lut_freq != pss_pkg::PSS_UNUSED) begin
      sel_speed = lut_speed;
    end else if (combo == 4'h8) begin
      sel_speed = 4'h3;
    end else begin
      sel_speed = basic_speed;
    end
    sel_freq = (sel_speed == 4'h0) ? 16'h0000
                                   : preset_q[sel_speed - 4'h1];
  end

  ////////////////////////////////////////////////////////////////////////
  // Source priority: jog, preset, analog 4, analog 2, then nothing
  always_comb begin
    speed_d = sel_speed;
    if (jog_src.valid) begin
      freq_d = jog_src;
      src_d  = pss_pkg::PSS_SRC_JOG;
    end else if (sel_speed != 4'h0) begin
      freq_d = '{valid: 1'b1, freq: sel_freq};
      src_d  = pss_pkg::PSS_SRC_PRESET;
    end else if (an4_src.valid) begin
      freq_d = an4_src;
      src_d  = pss_pkg::PSS_SRC_AN4;
    end else if (an2_src.valid) begin
      freq_d = an2_src;
      src_d  = pss_pkg::PSS_SRC_AN2;
    end else begin
      freq_d = '{valid: 1'b0, freq: 16'h0000};
      src_d  = pss_pkg::PSS_SRC_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_q  <= '{valid: 1'b0, freq: 16'h0000};
      src_q   <= pss_pkg::PSS_SRC_NONE;
      speed_q <= 4'h0;
    end else begin
      freq_q  <= freq_d;
      src_q   <= src_d;
      speed_q <= speed_d;
    end
  end

  assign freq_cmd    = freq_q;
  assign freq_source = src_q;
  assign speed_sel   = speed_q;

  ////////////////////////////////////////////////////////////////////////
  // APB decode; always ready, so the access phase is a single cycle
  assign pready   = 1'b1;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pidx     = paddr[5:2];
  assign wval     = pwdata[15:0];
  assign is_preset = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00) &&
                     (pidx != 4'hF);
  assign addr_ok  = is_preset || paddr == pss_pkg::PSS_OFS_CONFIG ||
                    paddr == pss_pkg::PSS_OFS_TERMFN ||
                    paddr == pss_pkg::PSS_OFS_STATUS;

  // Range and display gate only; running state never blocks a preset
  always_comb begin
    if (!is_preset) begin
      wr_ok = (paddr != pss_pkg::PSS_OFS_STATUS);
    end else if (pidx < 4'h3) begin
      wr_ok = (wval <= pss_pkg::PSS_FREQ_MAX);
    end else begin
      wr_ok = (eds == 8'h00) &&
              (wval <= pss_pkg::PSS_FREQ_MAX ||
               wval == pss_pkg::PSS_UNUSED);
    end
  end

  // Errors only in the access phase; a write to status is refused
  assign pslverr = psel && penable &&
                   (!addr_ok || (pwrite && !wr_ok));

  ////////////////////////////////////////////////////////////////////////
  // Register write path
  always_comb begin
    cfg_d    = cfg_q;
    termfn_d = termfn_q;
    for (int i = 0; i < pss_pkg::PSS_NUM_PRESET; i++) begin
      preset_d[i] = preset_q[i];
    end
    if (wr_acc && wr_ok && addr_ok) begin
      if (is_preset) begin
        preset_d[pidx] = wval;
      end else if (paddr == pss_pkg::PSS_OFS_CONFIG) begin
        cfg_d = {8'h00, pwdata[23:0]};
      end else begin
        termfn_d = pwdata[19:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q    <= pss_pkg::PSS_CFG_RST;
      termfn_q <= pss_pkg::PSS_TERMFN_RST;
      for (int i = 0; i < pss_pkg::PSS_NUM_PRESET; i++) begin
        preset_q[i] <= pss_pkg::PSS_PRESET_RST[i];
      end
    end else begin
      cfg_q    <= cfg_d;
      termfn_q <= termfn_d;
      for (int i = 0; i < pss_pkg::PSS_NUM_PRESET; i++) begin
        preset_q[i] <= preset_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data is captured in setup so it stands through the access phase
  always_comb begin
    prdata_d = 32'h0000_0000;
    if (rd_setup) begin
      if (is_preset) begin
        prdata_d = {16'h0000, preset_q[pidx]};
      end else if (paddr == pss_pkg::PSS_OFS_CONFIG) begin
        prdata_d = cfg_q;
      end else if (paddr == pss_pkg::PSS_OFS_TERMFN) begin
        prdata_d = {12'h000, termfn_q};
      end else if (paddr == pss_pkg::PSS_OFS_STATUS) begin
        prdata_d = {19'h0_0000, sync2_q, 1'b0, src_q, speed_q};
      end
    end else if (psel && penable) begin
      prdata_d = prdata_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [15:0] p_high, p_mid, p_low, p_sp4, p_sp8;
  assign p_high = preset_q[0];
  assign p_mid  = preset_q[1];
  assign p_low  = preset_q[2];
  assign p_sp4  = preset_q[3];
  assign p_sp8  = preset_q[7];

  sequence s_preset_path;
    !jog_src.valid && rss == 8'h00;
  endsequence

  AST_HIGH: assert property (
    s_preset_path and (combo == 4'h4) |=>
      src_q == pss_pkg::PSS_SRC_PRESET && freq_q.freq == $past(p_high))
    else $error("high select did not command high preset");

  AST_MID: assert property (
    s_preset_path and (combo == 4'h2) |=>
      src_q == pss_pkg::PSS_SRC_PRESET && freq_q.freq == $past(p_mid))
    else $error("middle select did not command middle preset");

  AST_LOW: assert property (
    s_preset_path and (combo == 4'h1) |=>
      speed_q == 4'h3 && freq_q.freq == $past(p_low))
    else $error("low select did not command low preset");

  AST_PRIO: assert property (
    rss == 8'h00 && combo == 4'h6 && p_sp4 == pss_pkg::PSS_UNUSED |->
      sel_speed == 4'h2)
    else $error("high and middle did not yield middle");

  AST_NOT_SEL: assert property (
    sel_speed >= pss_pkg::PSS_FIRST_EXT |-> sel_freq != pss_pkg::PSS_UNUSED)
    else $error("unused extended speed was selected");

  AST_RANGE: assert property (
    src_q == pss_pkg::PSS_SRC_PRESET |-> freq_q.freq <= pss_pkg::PSS_FREQ_MAX)
    else $error("preset command beyond 400 Hz");

  AST_RUN_WR: assert property (
    wr_acc && is_preset && pidx < 4'h3 &&
    wval <= pss_pkg::PSS_FREQ_MAX |-> !pslverr ##1 preset_q[$past(pidx)]
      == $past(wval))
    else $error("basic preset write was refused");

  AST_GATE: assert property (
    wr_acc && is_preset && pidx >= 4'h3 && eds != 8'h00 |->
      pslverr ##1 $stable(p_sp4) && $stable(p_sp8))
    else $error("extended preset written while hidden");

  AST_EXT8: assert property (
    s_preset_path and (combo == 4'h8 && p_sp8 == pss_pkg::PSS_UNUSED) |=>
      speed_q == 4'h3 && freq_q.freq == $past(p_low))
    else $error("extension alone did not fall back to low");

  AST_JOG: assert property (
    jog_src.valid |=> src_q == pss_pkg::PSS_SRC_JOG &&
      freq_q == $past(jog_src))
    else $error("jog did not take precedence");

  AST_REMOTE: assert property (
    rss != 8'h00 |=> speed_q == 4'h0 &&
      src_q != pss_pkg::PSS_SRC_PRESET)
    else $error("preset selected while remote setting is on");

  AST_IDLE: assert property (
    combo == 4'h0 && !jog_src.valid && !an4_src.valid &&
    !an2_src.valid |=> !freq_q.valid ##1 1'b1)
    else $error("command asserted with no source");

  // Table entry 12 is extension plus high; speed 9 once it is set
  AST_LUT: assert property (
    s_preset_path and (combo == 4'hC &&
      preset_q[8] != pss_pkg::PSS_UNUSED) |=> speed_q == 4'h9)
    else $error("extension with high did not pick speed 9");

  // Reset map: terminals 0 to 2 carry low, middle, high; no extension
  AST_MAP_RST: assert property (
    termfn_q == pss_pkg::PSS_TERMFN_RST |->
      combo == {1'b0, sync2_q[2:0]})
    else $error("reset terminal map does not follow own terminals");

  AST_MOVE: assert property (
    sync2_q[4] && termfn_q[19:16] == pss_pkg::PSS_FN_HIGH |-> sel_high)
    else $error("high select not taken from a moved terminal");

  AST_EXT_MAP: assert property (
    sync2_q[3] && termfn_q[15:12] == pss_pkg::PSS_FN_EXT |-> sel_ext)
    else $error("code 8 terminal did not raise extension select");

endmodule
`default_nettype wire

// [tb/pss_contacts.sv]
// Purpose: Contact model standing in for switches or a controller output.
// Assumes: Contacts change just after a clock edge, as relay outputs do.
// Notes:   No bounce is modelled; the design's two sync flops would not filter it.
`timescale 1ns/1ns
`default_nettype none
module pss_contacts (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [4:0] want,
  output logic      [4:0] term_pin
);
  ////////////////////////////////////////////////////////////////////////
  // Contacts open while the drive is held in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_pin <= 5'h00;
    end else begin
      term_pin <= want; // One edge late, like a real output stage
    end
  end
endmodule
`default_nettype wire

// [tb/pss_selector_tb_top.sv]
// Purpose: Self-checking bench for the preset speed selector.
// Assumes: Zero-wait APB slave; pin changes land within five edges.
// Notes:   Expected values are written out here, not read from the design.
`timescale 1ns/1ns
`default_nettype none
module pss_selector_tb_top;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [4:0]         want;
  logic [4:0]         term_pin;
  pss_pkg::pss_freq_t jog_src;
  pss_pkg::pss_freq_t an4_src;
  pss_pkg::pss_freq_t an2_src;
  pss_pkg::pss_freq_t freq_cmd;
  pss_pkg::pss_src_t  freq_source;
  logic [3:0]         speed_sel;
  logic [31:0]        rd;
  logic               err;
  int                 bad_count;
  int                 checks;

  pss_selector pss_selector_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .term_pin(term_pin), .jog_src(jog_src),
    .an4_src(an4_src), .an2_src(an2_src), .freq_cmd(freq_cmd),
    .freq_source(freq_source), .speed_sel(speed_sel));
  pss_contacts pss_contacts_i (.pclk(pclk), .presetn(presetn),
    .want(want), .term_pin(term_pin));

  ////////////////////////////////////////////////////////////////////////
  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run; every hang also ends here
  task automatic close_out();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("pready", 32'h0000_0001, 32'h0000_0000);
      close_out();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d,
                      input logic e);
    apb(1'b1, a, d);
    chk("write pslverr", {31'h0, e}, {31'h0, err});
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] d,
                      input logic e);
    apb(1'b0, a, 32'h0000_0000);
    chk("read pslverr", {31'h0, e}, {31'h0, err});
    chk("prdata", d, rd);
  endtask

  // Contacts change, then enough edges for the sync and the register
  task automatic pins(input logic [4:0] p);
    @(posedge pclk);
    want <= p;
    repeat (5) @(posedge pclk);
    #1;
  endtask

  task automatic srcs(input logic [16:0] j, input logic [16:0] a4,
                      input logic [16:0] a2);
    @(posedge pclk);
    jog_src <= j;
    an4_src <= a4;
    an2_src <= a2;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // Frequency is compared only when a valid command is expected
  task automatic cmd(input logic v, input logic [15:0] f,
                     input logic [2:0] s, input logic [3:0] sp);
    chk("cmd valid", {31'h0, v}, {31'h0, freq_cmd.valid});
    if (v) chk("cmd freq", {16'h0, f}, {16'h0, freq_cmd.freq});
    chk("freq_source", {29'h0, s}, {29'h0, freq_source});
    if (sp != 4'hF) chk("speed_sel", {28'h0, sp}, {28'h0, speed_sel});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    want = 5'h00;
    jog_src = '0;
    an4_src = '0;
    an2_src = '0;
    bad_count = 0;
    checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      rreg(8'(4 * i), (i == 0) ? 32'h0000_0258 : (i == 1) ? 32'h0000_012C :
           (i == 2) ? 32'h0000_0064 : 32'h0000_270F, 1'b0);
    end
    rreg(8'h40, 32'h0000_0000, 1'b0);
    rreg(8'h44, 32'h000F_F210, 1'b0);
    rreg(8'h80, 32'h0000_0000, 1'b1);
    wreg(8'h48, 32'h0000_0001, 1'b1);
    cmd(1'b0, 16'h0000, 3'h0, 4'h0);
    pins(5'b00100);
    cmd(1'b1, 16'h0258, 3'h2, 4'h1);
    pins(5'b00010);
    cmd(1'b1, 16'h012C, 3'h2, 4'h2);
    pins(5'b00001);
    cmd(1'b1, 16'h0064, 3'h2, 4'h3);
    pins(5'b00110);
    cmd(1'b1, 16'h012C, 3'h2, 4'h2);
    pins(5'b00111);
    cmd(1'b1, 16'h0064, 3'h2, 4'h3);
    // Retune the high preset while it is the running command
    pins(5'b00100);
    wreg(8'h00, 32'h0000_01F4, 1'b0);
    repeat (2) @(posedge pclk);
    #1;
    cmd(1'b1, 16'h01F4, 3'h2, 4'h1);
    rreg(8'h48, 32'h0000_0421, 1'b0);
    srcs(17'h1_0032, 17'h0_0000, 17'h0_0000);
    cmd(1'b1, 16'h0032, 3'h1, 4'hF);
    srcs(17'h0_0000, 17'h1_0200, 17'h1_0100);
    cmd(1'b1, 16'h01F4, 3'h2, 4'h1);
    pins(5'b00000);
    cmd(1'b1, 16'h0200, 3'h3, 4'h0);
    srcs(17'h0_0000, 17'h0_0000, 17'h1_0100);
    cmd(1'b1, 16'h0100, 3'h4, 4'h0);
    srcs(17'h0_0000, 17'h0_0000, 17'h0_0000);
    // Range edges of an extended preset; 9999 refused on a basic one
    wreg(8'h0C, 32'h0000_0FA0, 1'b0);
    wreg(8'h0C, 32'h0000_0FA1, 1'b1);
    rreg(8'h0C, 32'h0000_0FA0, 1'b0);
    wreg(8'h0C, 32'h0000_270F, 1'b0);
    wreg(8'h00, 32'h0000_270F, 1'b1);
    // Extension select on terminal 3
    wreg(8'h44, 32'h000F_8210, 1'b0);
    pins(5'b01000);
    cmd(1'b1, 16'h0064, 3'h2, 4'h3);
    wreg(8'h1C, 32'h0000_04D2, 1'b0);
    repeat (2) @(posedge pclk);
    #1;
    cmd(1'b1, 16'h04D2, 3'h2, 4'h8);
    wreg(8'h20, 32'h0000_0BB8, 1'b0);
    pins(5'b01100);
    cmd(1'b1, 16'h0BB8, 3'h2, 4'h9);
    // Display gate blocks extended writes only
    wreg(8'h40, 32'h0000_0100, 1'b0);
    wreg(8'h24, 32'h0000_0001, 1'b1);
    rreg(8'h24, 32'h0000_270F, 1'b0);
    wreg(8'h08, 32'h0000_0064, 1'b0);
    wreg(8'h40, 32'h0000_0000, 1'b0);
    // Low moved to terminal 4, then high placed there
    wreg(8'h44, 32'h0000_F21F, 1'b0);
    pins(5'b10000);
    cmd(1'b1, 16'h0064, 3'h2, 4'h3);
    pins(5'b00001);
    cmd(1'b0, 16'h0000, 3'h0, 4'h0);
    wreg(8'h44, 32'h0002_F210, 1'b0);
    pins(5'b10000);
    cmd(1'b1, 16'h01F4, 3'h2, 4'h1);
    wreg(8'h44, 32'h000F_F210, 1'b0);
    // Remote mode turns the basic contacts away from presets
    wreg(8'h40, 32'h0001_0000, 1'b0);
    pins(5'b00100);
    cmd(1'b0, 16'h0000, 3'h0, 4'h0);
    close_out();
  end
endmodule
`default_nettype wire
